// ### src/vic.sv
// vic: vectored prioritised interrupt controller with Avalon-MM slave
// assumes a core that acks one request, then signals return when done
`default_nettype none
module vic (
    input  wire logic                       REF_CLK,
    input  wire logic                       SRST,
    input  wire logic [7:0]                 AVS_ADDRESS,
    input  wire logic                       AVS_READ,
    input  wire logic                       AVS_WRITE,
    input  wire logic [31:0]                AVS_WRITEDATA,
    input  wire logic [3:0]                 AVS_BYTEENABLE,
    output logic      [31:0]                AVS_READDATA,
    output logic                            AVS_WAITREQUEST,
    input  wire logic [vic_pkg::NUM_SRC-1:0]  SRC_IRQ,
    input  wire logic [vic_pkg::NUM_TRAP-1:0] TRAP_IRQ,
    output logic                            CPU_IRQ,
    output logic      [6:0]                 CPU_SLOT,
    output logic      [23:0]                CPU_VECTOR_ADDR,
    output logic      [3:0]                 CPU_LEVEL,
    input  wire logic                       CPU_ACK,
    input  wire logic                       CPU_RETURN,
    input  wire logic [23:0]                CPU_SAVED_PC,
    output logic      [23:0]                CPU_RESUME_PC,
    output logic                            CPU_RESUME_VALID,
    output logic      [23:0]                CPU_RESET_PC
);
    // peripheral pins are asynchronous: two stages before use
    logic [vic_pkg::NUM_SRC-1:0]  src_s1_r, src_s2_r;
    logic [vic_pkg::NUM_TRAP-1:0] trap_s1_r, trap_s2_r;
    logic [vic_pkg::NUM_SRC-1:0]  flag_r, ena_r;
    logic [2:0]  prio_r [vic_pkg::NUM_SRC];
    logic [vic_pkg::NUM_TRAP-1:0] trap_flag_r;
    logic        nestdis_r, altsel_r;
    logic [3:0]  cpu_level_r;
    logic [7:0]  timed_interrupt_disable_cnt_r;
    logic [3:0]  stack_lvl_r [8];
    logic [23:0] stack_pc_r  [8];
    logic [2:0]  sp_r;
    logic        in_isr_r;
    logic        ack_pend_r;
    logic        wr_hit, rd_phase_r;
    logic [15:0] wd;
    vic_pkg::request_t best;

    always_ff @(posedge REF_CLK)
    begin
        src_s1_r  <= SRC_IRQ;
        src_s2_r  <= src_s1_r;
        trap_s1_r <= TRAP_IRQ;
        trap_s2_r <= trap_s1_r;
    end

    assign wd = AVS_WRITEDATA[15:0];
    // one-wait-state slave: writes and reads complete in second cycle
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~rd_phase_r;
    assign wr_hit = AVS_WRITE & rd_phase_r & (&AVS_BYTEENABLE[1:0]);

    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
            rd_phase_r <= 1'b0;
        else
            rd_phase_r <= (AVS_READ | AVS_WRITE) & ~rd_phase_r;
    end

    // user flags: hardware set wins over a software clear
    // a pin pulse landing in the cycle of a clearing write is kept,
    // so software never loses a request it has not yet seen
    genvar g;
    generate
        for (g = 0; g < vic_pkg::NUM_SRC; g++)
        begin : g_src
            always_ff @(posedge REF_CLK)
            begin
                if (SRST)
                begin
                    flag_r[g] <= 1'b0;
                    ena_r[g]  <= 1'b0;
                    prio_r[g] <= vic_pkg::PRIO_RESET;
                end
                else
                begin
                    if (wr_hit && g < 16 &&
                        AVS_ADDRESS == vic_pkg::OFS_FLAGS0)
                        flag_r[g] <= wd[g % 16];
                    if (wr_hit && g >= 16 &&
                        AVS_ADDRESS == vic_pkg::OFS_FLAGS1)
                        flag_r[g] <= wd[g % 16];
                    if (wr_hit && g == vic_pkg::SER1ERR_SRC &&
                        AVS_ADDRESS == vic_pkg::OFS_FLAGS4)
                        flag_r[g] <= wd[vic_pkg::SER1ERR_FLAG_BIT];
                    if (src_s2_r[g])
                        flag_r[g] <= 1'b1;
                    if (wr_hit && g < 16 &&
                        AVS_ADDRESS == vic_pkg::OFS_ENA0)
                        ena_r[g] <= wd[g % 16];
                    if (wr_hit && g >= 16 &&
                        AVS_ADDRESS == vic_pkg::OFS_ENA1)
                        ena_r[g] <= wd[g % 16];
                    if (wr_hit && AVS_ADDRESS ==
                        8'(vic_pkg::OFS_PRIO_BASE + 8'(4 * g)))
                        prio_r[g] <= wd[2:0];
                    if (wr_hit && g == vic_pkg::SER1ERR_SRC &&
                        AVS_ADDRESS == vic_pkg::OFS_PRIO16)
                        prio_r[g] <= wd[vic_pkg::SER1ERR_PRIO_LO +: 3];
                end
            end
        end
    endgenerate

    // control registers, trap flags sticky until software clears
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            trap_flag_r <= '0;
            nestdis_r   <= 1'b0;
            altsel_r    <= 1'b0;
        end
        else
        begin
            if (wr_hit && AVS_ADDRESS == vic_pkg::OFS_CTRL1)
            begin
                nestdis_r   <= wd[vic_pkg::NESTDIS_BIT];
                trap_flag_r <= wd[vic_pkg::NUM_TRAP-1:0] | trap_s2_r;
            end
            else
                trap_flag_r <= trap_flag_r | trap_s2_r;
            if (wr_hit && AVS_ADDRESS == vic_pkg::OFS_CTRL2)
                altsel_r <= wd[vic_pkg::ALTSEL_BIT];
        end
    end

    // timed disable: software loads a cycle count that runs down
    // the count is in clock cycles, not instructions; a reload restarts it
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
            timed_interrupt_disable_cnt_r <= '0;
        else if (wr_hit && AVS_ADDRESS == vic_pkg::OFS_TIMED_INTERRUPT_DISABLE)
            timed_interrupt_disable_cnt_r <= wd[7:0];
        else if (timed_interrupt_disable_cnt_r != '0)
            timed_interrupt_disable_cnt_r <= timed_interrupt_disable_cnt_r - 8'h01;
    end

    // arbitration: traps first, then level, lowest slot breaks ties
    // scanning from the top slot down lets the lower slot overwrite on
    // an equal level, which keeps the natural order without a tree
    always_comb
    begin
        logic [3:0] lvl;
        lvl = '0;
        best = '0;
        for (int i = vic_pkg::NUM_SRC - 1; i >= 0; i--)
        begin
            lvl = {1'b0, prio_r[i]};
            if (flag_r[i] && ena_r[i] && prio_r[i] != vic_pkg::PRIO_OFF
                && !(timed_interrupt_disable_cnt_r != '0 && lvl < vic_pkg::TIMED_INTERRUPT_DISABLE_EXEMPT)
                && (!best.valid || lvl >= best.level))
            begin
                best.valid   = 1'b1;
                best.is_trap = 1'b0;
                best.slot    = 7'(vic_pkg::TRAP_SLOTS + i);
                best.level   = lvl;
            end
        end
        // user levels only clear a lower cpu level; nesting may block
        if (best.valid && (best.level <= cpu_level_r ||
            cpu_level_r >= vic_pkg::CPU_MASK_ALL ||
            (nestdis_r && in_isr_r)))
            best.valid = 1'b0;
        // traps are never masked by nesting or timed disable
        for (int t = vic_pkg::NUM_TRAP - 1; t >= 0; t--)
        begin
            lvl = 4'(vic_pkg::TRAP_LEVEL + 4'(vic_pkg::NUM_TRAP - 1 - t));
            if (trap_flag_r[t] && lvl > cpu_level_r)
            begin
                best.valid   = 1'b1;
                best.is_trap = 1'b1;
                best.slot    = 7'(t);
                best.level   = lvl;
            end
        end
    end

    // single request line to the core with the chosen vector
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            CPU_IRQ         <= 1'b0;
            CPU_SLOT        <= '0;
            CPU_VECTOR_ADDR <= vic_pkg::RESET_PC;
            CPU_LEVEL       <= '0;
        end
        else
        begin
            CPU_IRQ   <= best.valid & ~CPU_ACK;
            CPU_SLOT  <= best.slot;
            CPU_LEVEL <= best.level;
            CPU_VECTOR_ADDR <= (altsel_r ? vic_pkg::ALT_TABLE_BASE
                               : vic_pkg::PRIMARY_TABLE_BASE)
                               + 24'(best.slot);
        end
    end

    // priority stack: ack pushes, return pops the saved state
    // eight levels deep; deeper nesting wraps and overwrites the oldest,
    // a limit the core must respect since request levels go up to eleven
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            cpu_level_r      <= '0;
            sp_r             <= '0;
            in_isr_r         <= 1'b0;
            CPU_RESUME_PC    <= vic_pkg::RESET_PC;
            CPU_RESUME_VALID <= 1'b0;
        end
        else
        begin
            CPU_RESUME_VALID <= 1'b0;
            if (CPU_ACK && CPU_IRQ)
            begin
                stack_lvl_r[sp_r] <= cpu_level_r;
                stack_pc_r[sp_r]  <= CPU_SAVED_PC;
                sp_r              <= sp_r + 3'h1;
                cpu_level_r       <= CPU_LEVEL;
                in_isr_r          <= 1'b1;
            end
            else if (CPU_RETURN && sp_r != '0)
            begin
                cpu_level_r      <= stack_lvl_r[sp_r - 3'h1];
                CPU_RESUME_PC    <= stack_pc_r[sp_r - 3'h1];
                CPU_RESUME_VALID <= 1'b1;
                sp_r             <= sp_r - 3'h1;
                in_isr_r         <= (sp_r != 3'h1);
            end
            else if (wr_hit && AVS_ADDRESS == vic_pkg::OFS_STATUS)
                cpu_level_r <= wd[3:0];
        end
    end

    assign CPU_RESET_PC = vic_pkg::RESET_PC;

    // register read mux, unmapped words read zero
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
            AVS_READDATA <= '0;
        else
        begin
            AVS_READDATA <= '0;
            unique case (AVS_ADDRESS)
                vic_pkg::OFS_CTRL1:  AVS_READDATA[15:0] <=
                    {nestdis_r, 11'h000, trap_flag_r};
                vic_pkg::OFS_CTRL2:  AVS_READDATA[15] <= altsel_r;
                vic_pkg::OFS_FLAGS0: AVS_READDATA[15:0] <= flag_r[15:0];
                vic_pkg::OFS_FLAGS1: AVS_READDATA[4:0]  <= flag_r[20:16];
                vic_pkg::OFS_ENA0:   AVS_READDATA[15:0] <= ena_r[15:0];
                vic_pkg::OFS_ENA1:   AVS_READDATA[4:0]  <= ena_r[20:16];
                vic_pkg::OFS_FLAGS4: AVS_READDATA[vic_pkg::SER1ERR_FLAG_BIT]
                    <= flag_r[vic_pkg::SER1ERR_SRC];
                vic_pkg::OFS_PRIO16: AVS_READDATA[6:4]
                    <= prio_r[vic_pkg::SER1ERR_SRC];
                vic_pkg::OFS_STATUS: AVS_READDATA[3:0] <= cpu_level_r;
                vic_pkg::OFS_TIMED_INTERRUPT_DISABLE:   AVS_READDATA[7:0] <= timed_interrupt_disable_cnt_r;
                default:
                    for (int k = 0; k < vic_pkg::NUM_SRC; k++)
                        if (AVS_ADDRESS ==
                            8'(vic_pkg::OFS_PRIO_BASE + 8'(4 * k)))
                            AVS_READDATA[2:0] <= prio_r[k];
            endcase
        end
    end

    trap_flag_sticky_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        trap_s2_r[0] |=> trap_flag_r[0])
        else $error("trap flag not set");
    irq_above_level_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        CPU_IRQ |-> $past(best.level) > $past(cpu_level_r))
        else $error("request not above cpu level");
    mask_all_user_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        (cpu_level_r >= 4'h7 && trap_flag_r == '0) |=> !CPU_IRQ)
        else $error("user request at cpu level 7");
    timed_interrupt_disable_low_block_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        (timed_interrupt_disable_cnt_r != '0 && $past(timed_interrupt_disable_cnt_r) != '0 && CPU_IRQ)
        |-> CPU_LEVEL >= 4'h7)
        else $error("timed disable leaked");
    vector_base_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        CPU_IRQ && !$past(altsel_r) |->
        CPU_VECTOR_ADDR == 24'h000004 + 24'(CPU_SLOT))
        else $error("bad primary vector");
    ack_raises_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        (CPU_ACK && CPU_IRQ) |=> cpu_level_r == $past(CPU_LEVEL))
        else $error("level not raised");
    return_restore_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        (CPU_RETURN && !(CPU_ACK && CPU_IRQ) && sp_r != '0)
        |=> cpu_level_r == $past(stack_lvl_r[sp_r - 3'h1]))
        else $error("level not restored");
    flag_hold_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        (flag_r[vic_pkg::SER1ERR_SRC] && !wr_hit)
        |=> flag_r[vic_pkg::SER1ERR_SRC])
        else $error("flag lost without clear");

    // the checks below watch only what this block drives; a core that
    // misbehaves on its own side is caught by the bench, not here

    // bus: one wait state, then the transfer completes
    wait_once_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        (AVS_WAITREQUEST && (AVS_READ || AVS_WRITE)) |=> !AVS_WAITREQUEST)
        else $error("second wait state");

    // the request line falls as soon as the core accepts
    irq_drop_ack_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        (CPU_ACK && CPU_IRQ) |=> !CPU_IRQ)
        else $error("request held after accept");

    // with nesting off a running service keeps user sources out
    nest_block_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        (nestdis_r && in_isr_r && trap_flag_r == '0)
        |=> !CPU_IRQ)
        else $error("preempted while nesting disabled");

    // alternate select moves the base for every vector
    vector_alt_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        CPU_IRQ && $past(altsel_r) |->
        CPU_VECTOR_ADDR == vic_pkg::ALT_TABLE_BASE + 24'(CPU_SLOT))
        else $error("bad alternate vector");

    // timed disable counts down by one each cycle until zero
    timed_interrupt_disable_countdown_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        (timed_interrupt_disable_cnt_r != '0 && !(wr_hit && AVS_ADDRESS == vic_pkg::OFS_TIMED_INTERRUPT_DISABLE))
        |=> timed_interrupt_disable_cnt_r == $past(timed_interrupt_disable_cnt_r) - 8'h01)
        else $error("timed disable count skipped");

    // a pending top trap reaches the core whatever the user masks say
    trap_unmasked_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        (trap_flag_r[0] && cpu_level_r < 4'hB && !CPU_ACK)
        |=> CPU_IRQ)
        else $error("trap held back");

    // software moves the cpu level when no entry or return competes
    status_write_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        (wr_hit && AVS_ADDRESS == vic_pkg::OFS_STATUS && !CPU_ACK
        && !CPU_RETURN) |=> cpu_level_r == $past(wd[3:0]))
        else $error("status write lost");

    // every accepted return hands back a resume address
    resume_given_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        (CPU_RETURN && !(CPU_ACK && CPU_IRQ) && sp_r != '0)
        |=> CPU_RESUME_VALID)
        else $error("no resume strobe");
endmodule
`default_nettype wire

// ### src/vic_pkg.sv
// vic_pkg: constants and types for the vectored interrupt controller
// assumes a 16-bit register bus carried in the low half of Avalon data
package vic_pkg;
    localparam int NUM_SRC  = 21;
    localparam int NUM_TRAP = 4;
    localparam int SRC_W    = 5;
    localparam logic [23:0] PRIMARY_TABLE_BASE = 24'h000004;
    localparam int          TABLE_ENTRIES      = 126;
    localparam int          TRAP_SLOTS         = 8;
    localparam int          USER_SLOTS         = 118;
    localparam logic [23:0] ALT_TABLE_BASE     = 24'h000004 + 24'd126;
    localparam logic [23:0] RESET_PC           = 24'h000000;
    // byte addresses of the register words
    localparam logic [7:0] OFS_CTRL1  = 8'h00;
    localparam logic [7:0] OFS_CTRL2  = 8'h04;
    localparam logic [7:0] OFS_FLAGS0 = 8'h08;
    localparam logic [7:0] OFS_FLAGS1 = 8'h0C;
    localparam logic [7:0] OFS_ENA0   = 8'h10;
    localparam logic [7:0] OFS_ENA1   = 8'h14;
    localparam logic [7:0] OFS_FLAGS4 = 8'h18;
    localparam logic [7:0] OFS_PRIO16 = 8'h1C;
    localparam logic [7:0] OFS_PRIO_BASE = 8'h40;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_TIMED_INTERRUPT_DISABLE   = 8'h24;
    localparam int NESTDIS_BIT = 15;
    localparam int ALTSEL_BIT  = 15;
    localparam int SER1ERR_SRC = 17;
    localparam int SER1ERR_FLAG_BIT = 1;
    localparam int SER1ERR_PRIO_LO  = 4;
    localparam logic [2:0] PRIO_RESET = 3'h4;
    localparam logic [2:0] PRIO_OFF   = 3'h0;
    localparam logic [3:0] CPU_MASK_ALL = 4'h7;
    localparam logic [3:0] TRAP_LEVEL   = 4'h8;
    localparam logic [3:0] TIMED_INTERRUPT_DISABLE_EXEMPT  = 4'h7;
    localparam logic [7:0] BIT_W      = 8'h10;
    typedef struct packed {
        logic        valid;
        logic        is_trap;
        logic [6:0]  slot;
        logic [3:0]  level;
    } request_t;
endpackage

// ### bench/core_model.sv
// core_model: behavioural processor core on the far side of the controller
// assumes one shared clock; the controller holds its request until acked
`default_nettype none
module core_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        irq,
    input  wire logic [6:0]  slot,
    input  wire logic [23:0] vec,
    input  wire logic [3:0]  level,
    input  wire logic [7:0]  lag,
    input  wire logic        ret_req,
    output logic             ack,
    output logic             ret,
    output logic      [23:0] pc,
    output logic      [6:0]  took_slot,
    output logic      [23:0] took_vec,
    output logic      [3:0]  took_level,
    output logic      [7:0]  takes
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_r;
    // accept after lag cycles; a slow core proves the request is held
    always_ff @(posedge clk)
    begin
        ret <= ret_req & ~rst;
        if (rst)
        begin
            ack <= 1'h0;
            cnt_r <= 8'h00;
            takes <= 8'h00;
            pc <= 24'h000100;
        end
        else if (ack)
        begin
            ack <= 1'h0;
            takes <= takes + 8'h01;
            took_slot <= slot;
            took_vec <= vec;
            took_level <= level;
            pc <= pc + 24'h000010; // each entry pushes a distinct address
        end
        else if (irq && cnt_r >= lag)
        begin
            ack <= 1'h1;
            cnt_r <= 8'h00;
        end
        else
            cnt_r <= irq ? cnt_r + 8'h01 : 8'h00;
    end
endmodule
`default_nettype wire

// ### bench/test_vic.sv
// test_vic: self-checking bench for the vectored interrupt controller
// assumes core_model answers on the core side; bench is the bus master
`default_nettype none
module test_vic;
    timeunit 1ns;
    timeprecision 1ns;
    logic                         clk, srst, rd, wr, irq, ack, ret;
    logic                         rvalid, ret_req, wreq;
    logic [7:0]                   adr, lag, takes, seen;
    logic [31:0]                  wdat, rdat;
    logic [vic_pkg::NUM_SRC-1:0]  src;
    logic [vic_pkg::NUM_TRAP-1:0] trap;
    logic [6:0]                   slot, t_slot;
    logic [23:0]                  vec, t_vec, pc, rpc, rst_pc;
    logic [3:0]                   lvl, t_lvl;
    int                           bad_count, n_tests;
    localparam logic [23:0] pbase = vic_pkg::PRIMARY_TABLE_BASE;
    localparam logic [23:0] abase = vic_pkg::ALT_TABLE_BASE;
    vic dut_u (.REF_CLK(clk), .SRST(srst), .AVS_ADDRESS(adr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat),
        .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
        .SRC_IRQ(src), .TRAP_IRQ(trap), .CPU_IRQ(irq), .CPU_SLOT(slot),
        .CPU_VECTOR_ADDR(vec), .CPU_LEVEL(lvl), .CPU_ACK(ack),
        .CPU_RETURN(ret), .CPU_SAVED_PC(pc), .CPU_RESUME_PC(rpc),
        .CPU_RESUME_VALID(rvalid), .CPU_RESET_PC(rst_pc));
    core_model core_u (.clk(clk), .rst(srst), .irq(irq), .slot(slot),
        .vec(vec), .level(lvl), .lag(lag), .ret_req(ret_req), .ack(ack),
        .ret(ret), .pc(pc), .took_slot(t_slot), .took_vec(t_vec),
        .took_level(t_lvl), .takes(takes));
    // free-running 100 MHz clock
    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    task automatic close_out();
        if (bad_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one transfer, held until waitrequest is sampled low at an edge
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [15:0] d, output logic [15:0] q);
        int n;
        @(posedge clk);
        adr <= a;
        wdat <= {16'h0000, d};
        wr <= w;
        rd <= ~w;
        @(posedge clk);
        for (n = 0; n < 50 && wreq !== 1'h0; n++) @(posedge clk);
        q = rdat[15:0];
        check("waitrequest", 32'h0, 32'(wreq));
        rd <= 1'h0;
        wr <= 1'h0;
    endtask
    task automatic wrt(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] q;
        bus(1'h1, a, d, q);
    endtask
    task automatic rdc(input string what, input logic [7:0] a,
                       input logic [15:0] exp);
        logic [15:0] q;
        bus(1'h0, a, 16'h0000, q);
        check(what, 32'(exp), 32'(q));
    endtask
    // wait for the core to accept, then judge what it was handed
    task automatic take(input logic [6:0] s, input logic [3:0] l,
                        input logic [23:0] base);
        int n;
        for (n = 0; n < 400 && takes === seen; n++) @(posedge clk);
        seen = takes;
        check("slot", 32'(s), 32'(t_slot));
        check("level", 32'(l), 32'(t_lvl));
        check("vector", 32'(base + 24'(s)), 32'(t_vec));
    endtask
    // the resume address must be the one pushed at entry
    task automatic back();
        int n;
        @(posedge clk);
        ret_req <= 1'h1;
        @(posedge clk);
        ret_req <= 1'h0;
        for (n = 0; n < 20 && rvalid !== 1'h1; n++) @(posedge clk);
        check("resume pc", 32'(pc - 24'h000010), 32'(rpc));
    endtask
    // no acceptance may happen over n cycles
    task automatic quiet(input int n);
        repeat (n) @(posedge clk);
        check("no request", 32'(seen), 32'(takes));
    endtask
    task automatic pulse(input logic [20:0] m);
        @(posedge clk);
        src <= m;
        @(posedge clk);
        src <= 21'h000000;
    endtask
    task automatic t_reset();
        rdc("prio16", vic_pkg::OFS_PRIO16, 16'h0040);
        rdc("prio src0", vic_pkg::OFS_PRIO_BASE, 16'h0004);
        rdc("flags4", vic_pkg::OFS_FLAGS4, 16'h0000);
        wrt(8'hFC, 16'hFFFF);
        rdc("unmapped", 8'hFC, 16'h0000);
        check("reset pc", 32'h00000000, 32'(rst_pc));
    endtask
    task automatic t_serial();
        wrt(vic_pkg::OFS_FLAGS4, 16'h0002);
        rdc("flags4 set", vic_pkg::OFS_FLAGS4, 16'h0002);
        quiet(20);
        wrt(vic_pkg::OFS_ENA1, 16'h0002);
        take(7'h19, 4'h4, pbase);
        rdc("cpu level", vic_pkg::OFS_STATUS, 16'h0004);
        back();
        take(7'h19, 4'h4, pbase);
        wrt(vic_pkg::OFS_FLAGS4, 16'h0000);
        back();
        quiet(20);
        rdc("cpu level", vic_pkg::OFS_STATUS, 16'h0000);
        wrt(vic_pkg::OFS_PRIO16, 16'h0000);
        pulse(21'h020000);
        quiet(20);
        lag <= 8'h05;
        wrt(vic_pkg::OFS_PRIO16, 16'h0070);
        take(7'h19, 4'h7, pbase);
        wrt(vic_pkg::OFS_FLAGS4, 16'h0000);
        back();
        wrt(vic_pkg::OFS_ENA1, 16'h0000);
        lag <= 8'h00;
    endtask
    task automatic t_order();
        wrt(vic_pkg::OFS_ENA0, 16'h0028);
        pulse(21'h000028);
        take(7'h0B, 4'h4, pbase);
        wrt(vic_pkg::OFS_FLAGS0, 16'h0020);
        back();
        take(7'h0D, 4'h4, pbase);
        wrt(vic_pkg::OFS_FLAGS0, 16'h0000);
        back();
        wrt(8'h54, 16'h0006);
        pulse(21'h000028);
        take(7'h0D, 4'h6, pbase);
        quiet(20);
        wrt(vic_pkg::OFS_FLAGS0, 16'h0008);
        back();
        take(7'h0B, 4'h4, pbase);
        wrt(vic_pkg::OFS_FLAGS0, 16'h0000);
        back();
    endtask
    task automatic t_nest();
        wrt(vic_pkg::OFS_CTRL1, 16'h8000);
        pulse(21'h000008);
        take(7'h0B, 4'h4, pbase);
        pulse(21'h000020);
        quiet(20);
        wrt(vic_pkg::OFS_FLAGS0, 16'h0020);
        back();
        take(7'h0D, 4'h6, pbase);
        wrt(vic_pkg::OFS_CTRL1, 16'h0000);
        wrt(vic_pkg::OFS_FLAGS0, 16'h0000);
        back();
    endtask
    task automatic t_mask();
        wrt(8'h54, 16'h0007);
        wrt(vic_pkg::OFS_STATUS, 16'h0007);
        pulse(21'h000020);
        quiet(20);
        trap <= 4'h1;
        @(posedge clk);
        trap <= 4'h0;
        take(7'h00, 4'hB, pbase);
        rdc("trap flag", vic_pkg::OFS_CTRL1, 16'h0001);
        back();
        take(7'h00, 4'hB, pbase);
        wrt(vic_pkg::OFS_CTRL1, 16'h0000);
        back();
        quiet(20);
        wrt(vic_pkg::OFS_STATUS, 16'h0000);
        take(7'h0D, 4'h7, pbase);
        wrt(vic_pkg::OFS_FLAGS0, 16'h0000);
        back();
    endtask
    task automatic t_alt_timed_interrupt_disable();
        wrt(vic_pkg::OFS_CTRL2, 16'h8000);
        wrt(vic_pkg::OFS_TIMED_INTERRUPT_DISABLE, 16'h00C8);
        pulse(21'h000028);
        take(7'h0D, 4'h7, abase);
        wrt(vic_pkg::OFS_FLAGS0, 16'h0008);
        back();
        quiet(20);
        take(7'h0B, 4'h4, abase);
        wrt(vic_pkg::OFS_FLAGS0, 16'h0000);
        back();
    endtask
    // watchdog sized well beyond the whole sequence
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        close_out();
    end
    // reset for 20 cycles, then the scenarios in order
    initial
    begin
        srst = 1'h1;
        {rd, wr, ret_req} = 3'h0;
        {adr, lag, seen, wdat} = 56'h0;
        {src, trap} = 25'h0;
        bad_count = 0;
        n_tests = 0;
        repeat (20) @(posedge clk);
        srst <= 1'h0;
        t_reset();
        t_serial();
        t_order();
        t_nest();
        t_mask();
        t_alt_timed_interrupt_disable();
        close_out();
    end
endmodule
`default_nettype wire
